// ==== core/enccr_top.sv ====
// Quadrature encoder counter with externally cleared compare reference
// Notes on behaviour
// - With clear enabled, high filtered trigger forces compare reference low.
// - Once cleared, reference stays low until the next update event.
// - Clearing acts only in compare or PWM modes, never in forced modes.
// - At 100% duty a cleared reference returns at next counter overflow.
// - Mode 001 counts input B edges, 010 input A, 011 both.
// - Counter steps on valid adjusted input edges only while enabled.
// - Direction updates on every single-input transition in any encoder mode; simultaneous edges on both inputs leave it unchanged.
// - Counter wraps between zero and reload value in both directions.
// - Compare logic keeps working while encoder drives the counter.
// - Input A edge direction depends on level of input B.
// - Input B edge direction depends on input A; unselected edges are not counted but still set direction.
// - Direction reads 0 counting up, 1 counting down.
//
// Implementation choices: the strobed register port and the placing of the registers.
`include "enccr_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module enccr_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [`ENCCR_AW-1:0] regAddr,
  input wire logic [`ENCCR_DW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [`ENCCR_DW-1:0] regRdata,
  // Pins
  input wire logic encoderInputA,
  input wire logic encoderInputB,
  input wire logic extTriggerInput,
  // Status outputs
  output logic ocRef,
  output logic countDir,
  output logic updateEvent
);
  localparam int CW = `ENCCR_CW;

  logic [2:0] pinS1_q;
  logic [2:0] pinS2_q;
  logic prevA_q;
  logic prevB_q;
  logic cen_q;
  logic [2:0] sms_q;
  logic pol1_q;
  logic pol2_q;
  logic etp_q;
  logic ece_q;
  logic [1:0] ext_trigger_prescaler_q;
  logic [CW-1:0] arr_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [CW-1:0] ccr_q;
  enccr_pkg::enccr_ocm_t mode_q;
  logic clrEn_q;
  logic dir_q;
  logic clr_q;
  logic matchRef_q;
  logic stepped_q;
  logic [`ENCCR_DW-1:0] rdata_q;
  logic ocRef_q;
  logic uev_q;

  // Bus decode
  wire wrCtrl = regWr && regAddr == `ENCCR_OFS_CTRL;
  wire wrArr = regWr && regAddr == `ENCCR_OFS_RELOAD;
  wire wrCnt = regWr && regAddr == `ENCCR_OFS_COUNT;
  wire wrCcr = regWr && regAddr == `ENCCR_OFS_COMPARE;
  wire wrChan = regWr && regAddr == `ENCCR_OFS_CHAN;
  wire swUpdate = regWr && regAddr == `ENCCR_OFS_EVENT && regWdata[`ENCCR_B_UG];

  // Adjusted inputs; the filter stage is a pass-through here
  wire adjA = pinS2_q[0] ^ pol1_q;
  wire adjB = pinS2_q[1] ^ pol2_q;
  wire filtered_ext_trigger = pinS2_q[2] ^ etp_q;

  // Encoder edge and direction decode
  wire edgeA = adjA ^ prevA_q;
  wire edgeB = adjB ^ prevB_q;
  wire oneEdge = edgeA ^ edgeB;
  wire upOnA = adjA ^ adjB;
  wire upOnB = ~(adjA ^ adjB);
  wire encUp = edgeA ? upOnA : upOnB;
  wire selA = sms_q == enccr_pkg::ENCCR_SMS_A || sms_q == enccr_pkg::ENCCR_SMS_AB;
  wire selB = sms_q == enccr_pkg::ENCCR_SMS_B || sms_q == enccr_pkg::ENCCR_SMS_AB;
  wire encMode = selA || selB;
  // Simultaneous edges on both inputs are not a valid quadrature step
  wire encStep = cen_q && oneEdge && ((selA && edgeA) || (selB && edgeB));
  wire intStep = cen_q && sms_q == enccr_pkg::ENCCR_SMS_OFF;
  wire step = encStep || intStep;
  wire stepUp = encMode ? encUp : 1'b1;
  wire wrapHi = stepUp && cnt_q == arr_q;
  wire wrapLo = !stepUp && cnt_q == `ENCCR_RST_ZERO16;
  wire update_event = (step && (wrapHi || wrapLo)) || swUpdate;
  wire dir_d = (encMode && oneEdge) ? ~encUp : dir_q;

  always_comb begin
    cnt_d = cnt_q;
    if (wrCnt) begin
      cnt_d = regWdata[CW-1:0];
    end else if (step) begin
      if (wrapHi) begin
        cnt_d = `ENCCR_RST_ZERO16;
      end else if (wrapLo) begin
        cnt_d = arr_q;
      end else if (stepUp) begin
        cnt_d = cnt_q + 16'h0001;
      end else begin
        cnt_d = cnt_q - 16'h0001;
      end
    end
  end

  // Compare reference; compare stays live in encoder mode
  wire cmpLt = dir_q ? (cnt_q <= ccr_q) : (cnt_q < ccr_q);
  wire matchHit = stepped_q && cnt_q == ccr_q;
  wire forced = mode_q == enccr_pkg::ENCCR_OC_FORCELO || mode_q == enccr_pkg::ENCCR_OC_FORCEHI;
  wire isPwm1 = mode_q == enccr_pkg::ENCCR_OC_PWM1;
  wire isPwm2 = mode_q == enccr_pkg::ENCCR_OC_PWM2;
  wire matchRef_d = !matchHit ? matchRef_q
    : mode_q == enccr_pkg::ENCCR_OC_SETHI ? 1'b1
    : mode_q == enccr_pkg::ENCCR_OC_SETLO ? 1'b0
    : mode_q == enccr_pkg::ENCCR_OC_TOGGLE ? ~matchRef_q : matchRef_q;
  wire rawRef = mode_q == enccr_pkg::ENCCR_OC_FORCEHI ? 1'b1
    : mode_q == enccr_pkg::ENCCR_OC_FORCELO ? 1'b0
    : isPwm1 ? cmpLt : isPwm2 ? ~cmpLt : matchRef_q;
  // Trigger level wins over an update in the same cycle
  wire clr_d = !forced && ((clrEn_q && filtered_ext_trigger) || (clr_q && !update_event));
  wire ocRef_d = rawRef && !clr_d;

  // Read mux; unmapped addresses read zero
  wire [`ENCCR_DW-1:0] ctrlRd = {21'h000000, dir_q, ext_trigger_prescaler_q, ece_q, etp_q,
    pol2_q, pol1_q, sms_q, cen_q};
  wire [`ENCCR_DW-1:0] rdSel = regAddr == `ENCCR_OFS_CTRL ? ctrlRd
    : regAddr == `ENCCR_OFS_RELOAD ? {16'h0000, arr_q}
    : regAddr == `ENCCR_OFS_COUNT ? {16'h0000, cnt_q}
    : regAddr == `ENCCR_OFS_COMPARE ? {16'h0000, ccr_q}
    : regAddr == `ENCCR_OFS_CHAN ? {28'h0000000, clrEn_q, mode_q}
    : regAddr == `ENCCR_OFS_STATUS ? {29'h00000000, dir_q, clr_q, ocRef_q}
    : 32'h00000000;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pinS1_q <= 3'h0;
      pinS2_q <= 3'h0;
    end else begin
      pinS1_q <= {extTriggerInput, encoderInputB, encoderInputA};
      pinS2_q <= pinS1_q;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cen_q <= 1'b0;
      sms_q <= 3'h0;
      pol1_q <= 1'b0;
      pol2_q <= 1'b0;
      etp_q <= 1'b0;
      ece_q <= 1'b0;
      ext_trigger_prescaler_q <= 2'h0;
    end else if (wrCtrl) begin
      cen_q <= regWdata[`ENCCR_B_CEN];
      sms_q <= regWdata[`ENCCR_B_SMS_HI:`ENCCR_B_SMS_LO];
      pol1_q <= regWdata[`ENCCR_B_POL1];
      pol2_q <= regWdata[`ENCCR_B_POL2];
      etp_q <= regWdata[`ENCCR_B_ETP];
      ece_q <= regWdata[`ENCCR_B_ECE];
      ext_trigger_prescaler_q <= regWdata[`ENCCR_B_EXT_TRIGGER_PRESCALER_HI:`ENCCR_B_EXT_TRIGGER_PRESCALER_LO];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      arr_q <= `ENCCR_RST_RELOAD;
      ccr_q <= `ENCCR_RST_ZERO16;
      mode_q <= enccr_pkg::ENCCR_OC_FROZEN;
      clrEn_q <= 1'b0;
    end else begin
      if (wrArr) arr_q <= regWdata[CW-1:0];
      if (wrCcr) ccr_q <= regWdata[CW-1:0];
      if (wrChan) begin
        mode_q <= enccr_pkg::enccr_ocm_t'(regWdata[`ENCCR_B_MODE_HI:`ENCCR_B_MODE_LO]);
        clrEn_q <= regWdata[`ENCCR_B_CLREN];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prevA_q <= 1'b0;
      prevB_q <= 1'b0;
      cnt_q <= `ENCCR_RST_ZERO16;
      dir_q <= 1'b0;
      stepped_q <= 1'b0;
      matchRef_q <= 1'b0;
      clr_q <= 1'b0;
      ocRef_q <= 1'b0;
      uev_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      prevA_q <= adjA;
      prevB_q <= adjB;
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      stepped_q <= step;
      matchRef_q <= matchRef_d;
      clr_q <= clr_d;
      ocRef_q <= ocRef_d;
      uev_q <= update_event;
      rdata_q <= regRd ? rdSel : 32'h00000000;
    end
  end

  assign regRdata = rdata_q;
  assign ocRef = ocRef_q;
  assign countDir = dir_q;
  assign updateEvent = uev_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence sClearReq;
    clrEn_q && filtered_ext_trigger && !forced;
  endsequence
  sequence sDownStep;
    step && !stepUp && cnt_q != `ENCCR_RST_ZERO16 && !wrCnt;
  endsequence

  a_clear_forces_low: assert property (sClearReq |=> !ocRef)
    else $error("reference not low under external clear");
  a_clear_holds: assert property (clr_q && !update_event && !forced && !wrChan |=> clr_q && !ocRef)
    else $error("clear released before update event");
  a_forced_ignores: assert property (
    mode_q == enccr_pkg::ENCCR_OC_FORCEHI && !wrChan |=> ocRef)
    else $error("forced high output was cleared");
  a_full_duty_back: assert property (
    isPwm1 && !dir_q && ccr_q > arr_q && cnt_q < ccr_q && update_event && !filtered_ext_trigger && !wrChan
    |=> ocRef)
    else $error("full duty reference not restored at overflow");
  a_hold_disabled: assert property (!cen_q && !wrCnt |=> $stable(cnt_q))
    else $error("counter moved while disabled");
  a_dir_on_edge: assert property (
    encMode && edgeA && !edgeB && (adjA ^ adjB) |=> !countDir)
    else $error("direction not up after up-going edge");
  a_wrap_up: assert property (step && wrapHi && !wrCnt |-> update_event ##1 cnt_q == 16'h0000)
    else $error("up wrap did not reach zero with update");
  a_ignore_unsel: assert property (
    sms_q == enccr_pkg::ENCCR_SMS_B && edgeA && !edgeB && !wrCnt |=> $stable(cnt_q))
    else $error("unselected input edge counted");
  a_down_step: assert property (sDownStep |=> cnt_q == $past(cnt_q) - 16'h0001)
    else $error("down step wrong");

  // Up steps that do not wrap, the down wrap end with its update, and count writes
  sequence sUpStep;
    step && stepUp && !wrapHi && !wrCnt;
  endsequence
  sequence sDownWrap;
    step && wrapLo && !wrCnt;
  endsequence
  a_up_step: assert property (sUpStep |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("up step wrong");
  a_wrap_down: assert property (sDownWrap |-> update_event ##1 cnt_q == $past(arr_q))
    else $error("down wrap did not reach reload value with update");
  a_count_write: assert property (wrCnt |=> cnt_q == $past(regWdata[CW-1:0]))
    else $error("count write not taken");

  // Direction follows each single-input transition, and only those
  a_dir_a_down: assert property (
    encMode && edgeA && !edgeB && !(adjA ^ adjB) |=> countDir)
    else $error("direction not down after down-going edge on input A");
  a_dir_b_up: assert property (
    encMode && edgeB && !edgeA && adjA == adjB |=> !countDir)
    else $error("direction not up after up-going edge on input B");
  a_dir_b_down: assert property (
    encMode && edgeB && !edgeA && adjA != adjB |=> countDir)
    else $error("direction not down after down-going edge on input B");
  a_dir_idle: assert property ((!encMode || !oneEdge) |=> $stable(countDir))
    else $error("direction moved without a transition");

  // Steps only from the selected input, never from a double edge
  a_ignore_unsel_b: assert property (
    sms_q == enccr_pkg::ENCCR_SMS_A && edgeB && !edgeA && !wrCnt |=> $stable(cnt_q))
    else $error("unselected input B edge counted");
  a_double_edge: assert property (
    encMode && edgeA && edgeB && !wrCnt |=> $stable(cnt_q))
    else $error("simultaneous edges counted");

  // Clear latch: set only when enabled, ended by an update, void in forced modes
  a_clear_ends: assert property (clr_q && update_event && !(clrEn_q && filtered_ext_trigger) |=> !clr_q)
    else $error("clear not ended by update event");
  a_clear_needs_en: assert property (!clrEn_q && !clr_q |=> !clr_q)
    else $error("clear latched while disabled");
  a_forced_no_clear: assert property (forced |=> !clr_q)
    else $error("clear latched in forced mode");
  a_forced_low: assert property (
    mode_q == enccr_pkg::ENCCR_OC_FORCELO && !wrChan |=> !ocRef)
    else $error("forced low output not low");
  a_pwm_level: assert property (isPwm1 && !clr_d && !wrChan |=> ocRef == $past(cmpLt))
    else $error("PWM reference does not follow compare");

  // Update pulse and read port timing
  a_update_pulse: assert property (1'b1 |=> updateEvent == $past(update_event))
    else $error("update pulse not one cycle after event");
  a_rd_idle: assert property (!regRd |=> regRdata == 32'h00000000)
    else $error("read data not zero outside read cycle");
endmodule // enccr_top
`default_nettype wire

// ==== dv/enccr_enc_model.sv ====
// Quadrature encoder stand-in driving the two encoder pins
`timescale 1ns/10ps
`default_nettype none
module enccr_enc_model (
  // Clock
  input wire logic ref_clk,
  // Encoder pins
  output logic pinA,
  output logic pinB
);
  logic [1:0] ph = 2'h0;
  assign pinA = ph[1] ^ ph[0];
  assign pinB = ph[1];
  // Gray order: only one pin moves per step, so the pins never switch together
  task automatic step(input logic up, input int gap, output logic wasA);
    wasA = up ? !ph[0] : ph[0];
    @(posedge ref_clk);
    ph <= up ? ph + 2'h1 : ph - 2'h1;
    repeat (gap) @(posedge ref_clk);
  endtask
endmodule // enccr_enc_model
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the encoder counter block
`include "enccr_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic [`ENCCR_AW-1:0] regAddr = '0;
  logic [`ENCCR_DW-1:0] regWdata = '0;
  logic regWr = 1'h0;
  logic regRd = 1'h0;
  logic extTriggerInput = 1'h0;
  wire logic [`ENCCR_DW-1:0] regRdata;
  wire logic encA, encB, ocRef, countDir, updateEvent;
  int err_total = 0;
  int n_compared = 0;
  int uevSeen = 0;
  int expUev = 0;
  logic [31:0] expQ[$], mskQ[$];
  logic [31:0] cfg[4] = '{32'h7, 32'h3, 32'h5, 32'h6};
  logic rdSeen = 1'h0;
  logic [15:0] rl, cnt;
  logic wasA, lastUp;
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  enccr_top i_enccr_top (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .encoderInputA(encA), .encoderInputB(encB), .extTriggerInput(extTriggerInput),
    .ocRef(ocRef), .countDir(countDir), .updateEvent(updateEvent));
  enccr_enc_model i_enccr_enc_model (.ref_clk(ref_clk), .pinA(encA), .pinB(encB));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Read data stand only in the cycle after the strobe, so compare exactly there
  always @(posedge ref_clk) begin
    if (rdSeen) chk("regRdata", expQ.pop_front(), regRdata & mskQ.pop_front());
    rdSeen <= regRd;
    if (updateEvent === 1'h1) uevSeen++;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge ref_clk);
    regWr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back(e & m);
    mskQ.push_back(m);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge ref_clk);
    regRd <= 1'h0;
  endtask
  // Move the encoder one step and predict count and wrap events
  task automatic mv(input logic up, input logic [2:0] m, input logic en);
    i_enccr_enc_model.step(up, 1 + $urandom % 4, wasA);
    lastUp = up;
    if (en && (m == 3'h3 || (m == 3'h2) == wasA)) begin
      if (up) cnt = (cnt == rl) ? 16'h0000 : cnt + 16'h0001;
      else cnt = (cnt == 16'h0000) ? rl : cnt - 16'h0001;
      expUev += (up ? cnt == 16'h0000 : cnt == rl);
    end
  endtask
  task automatic chkPos();
    repeat (4) @(posedge ref_clk);
    rd(`ENCCR_OFS_COUNT, {16'h0000, cnt}, '1);
    rd(`ENCCR_OFS_STATUS, {29'h0, !lastUp, 2'h0}, 32'h4);
    chk("countDir", {31'h0, !lastUp}, {31'h0, countDir});
  endtask
  task automatic trig(input int n);
    @(posedge ref_clk);
    extTriggerInput <= 1'h1;
    repeat (n) @(posedge ref_clk);
    extTriggerInput <= 1'h0;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic tally_and_finish();
    repeat (3) @(posedge ref_clk);
    $display("Compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    $display("[FAIL] watchdog expected finish seen hang");
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h93D0));
    repeat (5) @(posedge ref_clk);
    rst <= 1'h0;
    rd(`ENCCR_OFS_RELOAD, 32'h0000FFFF, '1);
    rd(`ENCCR_OFS_COUNT, 32'h0, '1);
    rd(8'h1C, 32'h0, '1);
    $display("Test reset values done");
    foreach (cfg[i]) begin
      rl = 16'h0002 + 16'($urandom % 8);
      cnt = 16'h0000;
      wr(`ENCCR_OFS_CTRL, 32'h0);
      wr(`ENCCR_OFS_RELOAD, {16'h0000, rl});
      wr(`ENCCR_OFS_COUNT, 32'h0);
      wr(`ENCCR_OFS_CTRL, cfg[i]);
      repeat (2 + $urandom % 10) mv(1'h1, cfg[i][3:1], cfg[i][0]);
      chkPos();
      repeat (3 + $urandom % 10) mv(1'h0, cfg[i][3:1], cfg[i][0]);
      chkPos();
      $display("Test encoder config %0d done", i);
    end
    wr(`ENCCR_OFS_CTRL, 32'h7);
    wr(`ENCCR_OFS_COMPARE, {16'h0000, rl} + 32'h1);
    wr(`ENCCR_OFS_CHAN, 32'hE);
    repeat (3) @(posedge ref_clk);
    rd(`ENCCR_OFS_STATUS, 32'h1, 32'h1);
    trig(4);
    rd(`ENCCR_OFS_STATUS, 32'h2, 32'h3);
    chk("ocRef cleared", 32'h0, {31'h0, ocRef});
    repeat (rl - cnt + 16'h0001) mv(1'h1, 3'h3, 1'h1);
    repeat (4) @(posedge ref_clk);
    rd(`ENCCR_OFS_STATUS, 32'h1, 32'h3);
    chk("ocRef restored", 32'h1, {31'h0, ocRef});
    wr(`ENCCR_OFS_CHAN, 32'hD);
    trig(6);
    rd(`ENCCR_OFS_STATUS, 32'h1, 32'h1);
    $display("Test trigger clear done");
    wr(`ENCCR_OFS_EVENT, 32'h1);
    expUev++;
    repeat (3) @(posedge ref_clk);
    chk("updateEvent count", expUev, uevSeen);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire

// ==== include/enccr_consts.svh ====
// Register offsets, field positions, reset values for the encoder counter block
`ifndef ENCCR_CONSTS_SVH
`define ENCCR_CONSTS_SVH
`define ENCCR_AW 8
`define ENCCR_DW 32
`define ENCCR_CW 16
`define ENCCR_OFS_CTRL 8'h00
`define ENCCR_OFS_RELOAD 8'h04
`define ENCCR_OFS_COUNT 8'h08
`define ENCCR_OFS_COMPARE 8'h0C
`define ENCCR_OFS_CHAN 8'h10
`define ENCCR_OFS_EVENT 8'h14
`define ENCCR_OFS_STATUS 8'h18
`define ENCCR_B_CEN 0
`define ENCCR_B_SMS_LO 1
`define ENCCR_B_SMS_HI 3
`define ENCCR_B_POL1 4
`define ENCCR_B_POL2 5
`define ENCCR_B_ETP 6
`define ENCCR_B_ECE 7
`define ENCCR_B_EXT_TRIGGER_PRESCALER_LO 8
`define ENCCR_B_EXT_TRIGGER_PRESCALER_HI 9
`define ENCCR_B_DIR 10
`define ENCCR_B_MODE_LO 0
`define ENCCR_B_MODE_HI 2
`define ENCCR_B_CLREN 3
`define ENCCR_B_UG 0
`define ENCCR_B_ST_REF 0
`define ENCCR_B_ST_CLR 1
`define ENCCR_B_ST_DIR 2
`define ENCCR_RST_RELOAD 16'hFFFF
`define ENCCR_RST_ZERO16 16'h0000
`endif

// ==== include/enccr_pkg.sv ====
// Types for the encoder counter block
package enccr_pkg;
  typedef enum logic [2:0] {
    ENCCR_SMS_OFF = 3'h0,
    ENCCR_SMS_B = 3'h1,
    ENCCR_SMS_A = 3'h2,
    ENCCR_SMS_AB = 3'h3
  } enccr_sms_t;
  typedef enum logic [2:0] {
    ENCCR_OC_FROZEN = 3'h0,
    ENCCR_OC_SETHI = 3'h1,
    ENCCR_OC_SETLO = 3'h2,
    ENCCR_OC_TOGGLE = 3'h3,
    ENCCR_OC_FORCELO = 3'h4,
    ENCCR_OC_FORCEHI = 3'h5,
    ENCCR_OC_PWM1 = 3'h6,
    ENCCR_OC_PWM2 = 3'h7
  } enccr_ocm_t;
endpackage
